/* File: rtl/erpl_pkg.sv */
// Functional notes
// RULE_01: Enabled pin: pull on if pull_device_disable is 0, off if it is 1.
// RULE_02: edge_polarity_select 0 senses falling or low, 1 rising or high.
// RULE_03: Rising sense with the pull on makes the pull a pulldown.
// RULE_04: pin_function_enable 0 disables the request pin, 1 enables it.
// RULE_05: Read-only request_flag is set by a qualifying event on the pin.
// RULE_06: request_acknowledge: 1 clears the flag, 0 is ignored, reads 0.
// RULE_07: Level mode: acknowledge cannot clear the flag at asserted level.
// RULE_08: request_interrupt_enable 1 raises the CPU request while flag is 1.
// RULE_09: level_detect_mode 0 detects edges, 1 edges and asserted level.
// RULE_10: The pin is synchronised to the bus clock before detection.
// RULE_11: Bit 7 of the status/control register reads zero and ignores writes.
package erpl_pkg;

  // ------------------------------------------------------------
  // Register map (byte addresses on a 32-bit Wishbone bus)
  // ------------------------------------------------------------
  localparam logic [3:0] ERPL_ADDR_CTRL   = 4'h0;
  localparam logic [3:0] ERPL_ADDR_STATUS = 4'h4;
  localparam logic [3:0] ERPL_ADDR_MASK   = 4'h8;

  // ------------------------------------------------------------
  // Status/control field positions
  // ------------------------------------------------------------
  localparam int ERPL_BIT_PDD = 6;
  localparam int ERPL_BIT_EDG = 5;
  localparam int ERPL_BIT_PE  = 4;
  localparam int ERPL_BIT_F   = 3;
  localparam int ERPL_BIT_ACK = 2;
  localparam int ERPL_BIT_IE  = 1;
  localparam int ERPL_BIT_MOD = 0;

  // ------------------------------------------------------------
  // Event status bits and reset values
  // ------------------------------------------------------------
  localparam int ERPL_EV_REQ = 0;
  localparam int ERPL_EV_W   = 1;
  localparam logic [7:0] ERPL_CTRL_RESET = 8'h00;
  localparam logic [0:0] ERPL_EV_RESET   = 1'h0;

  typedef enum logic [1:0] {
    ERPL_PULL_NONE,
    ERPL_PULL_UP,
    ERPL_PULL_DOWN
  } erpl_pull_t;

endpackage

/* File: rtl/erpl_sync.sv */
`timescale 1ns/1ps
module erpl_sync
  import erpl_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Level in and out
  input  wire logic din,
  output logic      dout
);

  logic meta_reg;
  logic sync_reg;

  // RULE_10: two-stage synchroniser
  always_ff @(posedge clk) begin
    if (reset) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= din;
      sync_reg <= meta_reg;
    end
  end

  assign dout = sync_reg;

endmodule

/* File: rtl/erpl_detect.sv */
`timescale 1ns/1ps
module erpl_detect
  import erpl_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // Synchronised pin and settings
  input  wire logic pin_sync,
  input  wire logic enable,
  input  wire logic rising,
  input  wire logic level_mode,
  // Detection results
  output logic      event_hit,
  output logic      asserted
);

  logic prev_reg;
  logic act_now;
  logic act_prev;
  logic edge_hit;

  always_ff @(posedge clk) begin
    if (reset) begin
      prev_reg <= 1'b0;
    end else begin
      prev_reg <= pin_sync;
    end
  end

  // RULE_02: polarity maps pin to active sense
  assign act_now  = rising ? pin_sync : ~pin_sync;
  assign act_prev = rising ? prev_reg : ~prev_reg;
  assign edge_hit = act_now & ~act_prev;
  assign asserted = enable & level_mode & act_now;
  // RULE_09: edge only, or edge plus level
  // RULE_04: disabled pin raises nothing
  assign event_hit = enable & (edge_hit | (level_mode & act_now));

endmodule

/* File: rtl/erpl_top.sv */
`timescale 1ns/1ps
module erpl_top
  import erpl_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Request pin
  input  wire logic        req_pin,
  output logic             pull_up_en,
  output logic             pull_down_en,
  // Interrupts
  output logic             cpu_request,
  output logic             irq
);

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic       pdd_reg;
  logic       edg_reg;
  logic       pe_reg;
  logic       flag_reg;
  logic       ie_reg;
  logic       mod_reg;
  logic [ERPL_EV_W-1:0] ev_status_reg;
  logic [ERPL_EV_W-1:0] ev_mask_reg;
  logic       flag_next;
  logic       ack_reg;
  logic [31:0] dat_reg;
  logic       pu_reg;
  logic       pd_reg;
  logic       cpu_reg;
  logic       irq_reg;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire        req_valid = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        wr_lane0  = req_valid & wb_we_i & wb_sel_i[0];
  wire        hit_ctrl  = (wb_adr_i == ERPL_ADDR_CTRL);
  wire        hit_stat  = (wb_adr_i == ERPL_ADDR_STATUS);
  wire        hit_mask  = (wb_adr_i == ERPL_ADDR_MASK);
  wire        wr_ctrl   = wr_lane0 & hit_ctrl;
  wire        wr_stat   = wr_lane0 & hit_stat;
  wire        wr_mask   = wr_lane0 & hit_mask;
  // RULE_06: write 1 acknowledges, 0 is ignored
  wire        ack_write = wr_ctrl & wb_dat_i[ERPL_BIT_ACK];

  // RULE_11: bit 7 and acknowledge read as zero
  wire [7:0]  ctrl_rd = {1'b0, pdd_reg, edg_reg, pe_reg, flag_reg,
                         1'b0, ie_reg, mod_reg};
  wire [31:0] rd_mux  = hit_ctrl ? {24'h000000, ctrl_rd} :
                        hit_stat ? {31'h00000000, ev_status_reg} :
                        hit_mask ? {31'h00000000, ev_mask_reg} :
                                   32'h00000000;

  // ------------------------------------------------------------
  // Pin path
  // ------------------------------------------------------------
  logic pin_sync;
  logic event_hit;
  logic asserted;

  erpl_sync u_sync (
    .clk   (clk),
    .reset (reset),
    .din   (req_pin),
    .dout  (pin_sync)
  );

  erpl_detect u_det (
    .clk        (clk),
    .reset      (reset),
    .pin_sync   (pin_sync),
    .enable     (pe_reg),
    .rising     (edg_reg),
    .level_mode (mod_reg),
    .event_hit  (event_hit),
    .asserted   (asserted)
  );

  // RULE_05: event sets flag, set wins over clear
  // RULE_07: held level keeps flag set
  assign flag_next = event_hit | asserted | (flag_reg & ~ack_write);

  // RULE_01: pull on when enabled and not disabled
  // RULE_03: rising sense turns pull into pulldown
  wire pull_on = pe_reg & ~pdd_reg;
  wire pu_next = pull_on & ~edg_reg;
  wire pd_next = pull_on & edg_reg;

  // RULE_08: request follows flag when enabled
  wire cpu_next = ie_reg & flag_next;
  // Status bit rises on a new flag set; set beats write-one-clear
  wire [ERPL_EV_W-1:0] ev_set = {flag_next & ~flag_reg};
  wire [ERPL_EV_W-1:0] ev_next =
    ev_set | (ev_status_reg & ~({ERPL_EV_W{wr_stat}} &
                                wb_dat_i[ERPL_EV_W-1:0]));
  wire irq_next = |(ev_next & ev_mask_reg);

  // ------------------------------------------------------------
  // Control register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      {pdd_reg, edg_reg, pe_reg} <= ERPL_CTRL_RESET[6:4];
      {ie_reg, mod_reg}          <= ERPL_CTRL_RESET[1:0];
    end else if (wr_ctrl) begin
      pdd_reg <= wb_dat_i[ERPL_BIT_PDD];
      edg_reg <= wb_dat_i[ERPL_BIT_EDG];
      pe_reg  <= wb_dat_i[ERPL_BIT_PE];
      ie_reg  <= wb_dat_i[ERPL_BIT_IE];
      mod_reg <= wb_dat_i[ERPL_BIT_MOD];
    end
  end

  // ------------------------------------------------------------
  // Flag, events, outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      flag_reg      <= 1'b0;
      ev_status_reg <= ERPL_EV_RESET;
      ev_mask_reg   <= ERPL_EV_RESET;
      pu_reg        <= 1'b0;
      pd_reg        <= 1'b0;
      cpu_reg       <= 1'b0;
      irq_reg       <= 1'b0;
    end else begin
      flag_reg      <= flag_next;
      ev_status_reg <= ev_next;
      if (wr_mask) begin
        ev_mask_reg <= wb_dat_i[ERPL_EV_W-1:0];
      end
      pu_reg  <= pu_next;
      pd_reg  <= pd_next;
      cpu_reg <= cpu_next;
      irq_reg <= irq_next;
    end
  end

  // ------------------------------------------------------------
  // Bus answer: one wait state, ack for one cycle
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req_valid;
      dat_reg <= req_valid ? rd_mux : 32'h00000000;
    end
  end

  assign wb_ack_o     = ack_reg;
  assign wb_dat_o     = dat_reg;
  assign pull_up_en   = pu_reg;
  assign pull_down_en = pd_reg;
  assign cpu_request  = cpu_reg;
  assign irq          = irq_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_pull_mode;
    @(posedge clk) disable iff (reset)
      1'b1 |=> (pull_up_en == ($past(pe_reg) & ~$past(pdd_reg)
                & ~$past(edg_reg)));
  endproperty
  a_pull_mode: assert property (p_pull_mode) // RULE_01
    else $error("pullup state wrong");

  property p_pull_down;
    @(posedge clk) disable iff (reset)
      (pe_reg & ~pdd_reg & edg_reg) |=> pull_down_en & ~pull_up_en;
  endproperty
  a_pull_down: assert property (p_pull_down) // RULE_03
    else $error("pulldown not applied");

  property p_rise_edge;
    @(posedge clk) disable iff (reset)
      (pe_reg & edg_reg & pin_sync & ~$past(pin_sync)) |=> flag_reg;
  endproperty
  a_rise_edge: assert property (p_rise_edge) // RULE_02
    else $error("rising edge missed");

  property p_disabled;
    @(posedge clk) disable iff (reset)
      (~pe_reg & ~flag_reg & ~ack_reg) |=> ~flag_reg;
  endproperty
  a_disabled: assert property (p_disabled) // RULE_04
    else $error("flag set while disabled");

  property p_flag_hold;
    @(posedge clk) disable iff (reset)
      (flag_reg & ~ack_write) |=> flag_reg;
  endproperty
  a_flag_hold: assert property (p_flag_hold) // RULE_05
    else $error("flag dropped without ack");

  property p_ack_clear;
    @(posedge clk) disable iff (reset)
      (ack_write & ~event_hit & ~asserted) |=> ~flag_reg;
  endproperty
  a_ack_clear: assert property (p_ack_clear) // RULE_06
    else $error("ack did not clear flag");

  property p_level_keep;
    @(posedge clk) disable iff (reset)
      (asserted & ack_write) |=> flag_reg;
  endproperty
  a_level_keep: assert property (p_level_keep) // RULE_07
    else $error("flag cleared at asserted level");

  property p_cpu_req;
    @(posedge clk) disable iff (reset)
      1'b1 |=> (cpu_request == ($past(ie_reg) & flag_reg));
  endproperty
  a_cpu_req: assert property (p_cpu_req) // RULE_08
    else $error("cpu request mismatch");

  property p_edge_only;
    @(posedge clk) disable iff (reset)
      (pe_reg & ~mod_reg & ~edg_reg & ~pin_sync & ~$past(pin_sync)
       & ack_write) |=> ~flag_reg;
  endproperty
  a_edge_only: assert property (p_edge_only) // RULE_09
    else $error("level set flag in edge mode");

  property p_bit7;
    @(posedge clk) disable iff (reset)
      wb_ack_o |-> (wb_dat_o[7] == 1'b0) && (wb_dat_o[ERPL_BIT_ACK] == 1'b0
                    || $past(~hit_ctrl));
  endproperty
  a_bit7: assert property (p_bit7) // RULE_11
    else $error("bit 7 or ack read nonzero");

  property p_pull_off;
    @(posedge clk) disable iff (reset)
      (~pe_reg | pdd_reg) |=> ~pull_up_en & ~pull_down_en;
  endproperty
  a_pull_off: assert property (p_pull_off) // RULE_01
    else $error("pull on while disabled");

  property p_fall_edge;
    @(posedge clk) disable iff (reset)
      (pe_reg & ~edg_reg & ~pin_sync & $past(pin_sync)) |=> flag_reg;
  endproperty
  a_fall_edge: assert property (p_fall_edge) // RULE_02
    else $error("falling edge missed");

  property p_no_source;
    @(posedge clk) disable iff (reset)
      ~pe_reg |-> ~event_hit & ~asserted;
  endproperty
  a_no_source: assert property (p_no_source) // RULE_04
    else $error("event from disabled pin");

  property p_flag_read;
    @(posedge clk) disable iff (reset)
      (wb_ack_o & hit_ctrl & ~wb_we_i)
        |-> (wb_dat_o[ERPL_BIT_F] == $past(flag_reg));
  endproperty
  a_flag_read: assert property (p_flag_read) // RULE_05
    else $error("flag read back wrong");

  property p_ev_set;
    @(posedge clk) disable iff (reset)
      $rose(flag_reg) |-> ev_status_reg[ERPL_EV_REQ];
  endproperty
  a_ev_set: assert property (p_ev_set) // RULE_05
    else $error("status missed new flag");

  property p_ev_sticky;
    @(posedge clk) disable iff (reset)
      (ev_status_reg[ERPL_EV_REQ] & ~wr_stat)
        |=> ev_status_reg[ERPL_EV_REQ];
  endproperty
  a_ev_sticky: assert property (p_ev_sticky) // RULE_05
    else $error("status dropped without clear");

  property p_level_set;
    @(posedge clk) disable iff (reset)
      (pe_reg & mod_reg & (pin_sync == edg_reg)) |=> flag_reg;
  endproperty
  a_level_set: assert property (p_level_set) // RULE_09
    else $error("held level did not set flag");

  property p_cpu_off;
    @(posedge clk) disable iff (reset)
      ~ie_reg |=> ~cpu_request;
  endproperty
  a_cpu_off: assert property (p_cpu_off) // RULE_08
    else $error("cpu request while disabled");

  property p_irq_level;
    @(posedge clk) disable iff (reset)
      1'b1 |=> (irq == |(ev_status_reg & $past(ev_mask_reg)));
  endproperty
  a_irq_level: assert property (p_irq_level) // RULE_08
    else $error("irq does not follow status");

endmodule

/* File: verif/erpl_pin_model.sv */
`timescale 1ns/1ps
module erpl_pin_model (
  // Clock
  input  wire logic clk,
  // Bench control of the external driver
  input  wire logic drv_en,
  input  wire logic drv_val,
  // Pull devices of the block
  input  wire logic pull_up_en,
  input  wire logic pull_down_en,
  // Pin level
  output logic      pin
);
  logic float_reg = 1'b0;

  // Undriven pin wanders, so a stale level never passes
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end

  assign pin = drv_en ? drv_val :
               pull_up_en ? 1'b1 :
               pull_down_en ? 1'b0 : float_reg;
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb
  import erpl_pkg::*;
;
  logic        clk, reset, cyc, stb, we, ack, pin, pu, pd;
  logic        cpu_request, irq, drv_en, drv_val, e, m;
  logic [3:0]  adr, sel;
  logic [31:0] wdat, rdat, q;
  logic [7:0]  cfg;
  int          err_total, num_checks, v;

  erpl_top erpl_top_inst (
    .clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .req_pin(pin),
    .pull_up_en(pu), .pull_down_en(pd),
    .cpu_request(cpu_request), .irq(irq)
  );

  erpl_pin_model erpl_pin_model_inst (
    .clk(clk), .drv_en(drv_en), .drv_val(drv_val),
    .pull_up_en(pu), .pull_down_en(pd), .pin(pin)
  );

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED %s exp %0h got %0h", nm, x, g);
    end
  endtask

  task chk_bit(input string nm, input logic x, input logic g);
    num_checks++;
    if (g !== x) begin
      err_total++;
      $display("CHECK FAILED %s exp %0b got %0b", nm, x, g);
    end
  endtask

  // One classic cycle; only the watchdog ends a wait on ack
  task wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= 4'h1;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  // Bit 7 and the acknowledge bit always read back as zero
  function logic [31:0] exp_rd(input logic [7:0] w, input logic f);
    return {24'h0, 1'b0, w[6:4], f, 1'b0, w[1:0]};
  endfunction

  task setc(input logic [7:0] c);
    cfg = c;
    wb(1'b1, ERPL_ADDR_CTRL, {24'hFFFFFF, c});
  endtask

  task rd_ctl(input logic f);
    wb(1'b0, ERPL_ADDR_CTRL, 32'h0);
    chk("ctrl", exp_rd(cfg, f), q);
  endtask

  task waitn;
    repeat (6) @(posedge clk);
  endtask

  // ----------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #(40 * 20000);
    err_total++;
    give_verdict;
  end

  initial begin
    reset = 1'b1;
    {cyc, stb, we, adr, sel, wdat} = '0;
    {drv_en, drv_val, err_total, num_checks, cfg} = '0;
    v = $urandom(31950);
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("pulls_rst", 32'h0, 32'({pu, pd, cpu_request, irq}));
    rd_ctl(1'b0);
    wb(1'b0, 4'hC, 32'h0);
    chk("unmapped", 32'h0, q);
    setc(8'hEF);
    rd_ctl(1'b0);
    repeat (8) begin
      drv_en  <= 1'($urandom);
      drv_val <= 1'($urandom);
      setc(8'($urandom));
      wb(1'b0, ERPL_ADDR_CTRL, 32'h0);
      chk("ctrl_rnd", exp_rd(cfg, 1'b0), q & 32'hFFFFFFF7);
      chk_bit("up", cfg[4] & ~cfg[6] & ~cfg[5], pu);
      chk_bit("down", cfg[4] & ~cfg[6] & cfg[5], pd);
    end
    wb(1'b1, ERPL_ADDR_MASK, 32'h1);
    for (int i = 0; i < 4; i++) begin
      {e, m} = 2'(i);
      drv_en  <= 1'b1;
      drv_val <= ~e;
      setc({2'b00, e, 3'b101, 1'b1, m});
      waitn;
      setc(cfg);
      wb(1'b1, ERPL_ADDR_STATUS, 32'h1);
      chk_bit("up_on", ~e, pu);
      chk_bit("down_on", e, pd);
      rd_ctl(1'b0);
      chk_bit("irq_idle", 1'b0, irq);
      drv_val <= e;
      waitn;
      chk_bit("cpu_req", 1'b1, cpu_request);
      chk_bit("irq_set", 1'b1, irq);
      setc(cfg & 8'hF9);
      chk_bit("poll", 1'b0, cpu_request);
      rd_ctl(1'b1);
      setc(cfg | 8'h06);
      rd_ctl(m);
      drv_val <= ~e;
      waitn;
      setc(cfg);
      rd_ctl(1'b0);
      wb(1'b1, ERPL_ADDR_STATUS, 32'h1);
      wb(1'b0, ERPL_ADDR_STATUS, 32'h0);
      chk("status_clr", 32'h0, q);
      chk_bit("irq_clr", 1'b0, irq);
    end
    setc(8'h52);
    chk("pull_off", 32'h0, 32'({pu, pd}));
    setc(8'h06);
    repeat (4) begin
      drv_val <= ~drv_val;
      waitn;
    end
    rd_ctl(1'b0);
    chk("req_off", 32'h0, 32'({pu, pd, cpu_request}));
    give_verdict;
  end
endmodule
